// >>> shared/boot_defines.svh
// Purpose: Constants of the reset and boot mode controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Boot mode codes follow the order of boot_pkg::boot_mode_t.
`ifndef BOOT_DEFINES_SVH
`define BOOT_DEFINES_SVH

// ----------------------------------------------------------------------
// Boot mode strap codes
// ----------------------------------------------------------------------
`define BOOT_MODE_W      2
`define BOOT_MODE_NONE   2'h0
`define BOOT_MODE_HOST   2'h1
`define BOOT_MODE_EXTERNAL_MEMORY_INTERFACE   2'h2

// ----------------------------------------------------------------------
// Boot copy geometry
// ----------------------------------------------------------------------
`define BOOT_COPY_BYTES  11'h400
`define BOOT_COPY_CNT_W  11
`define BOOT_LAST_BYTE   11'h3FF
`define BOOT_SRC_BASE    32'h90000000
`define BOOT_DEST_BASE   32'h00000000
`define CPU_START_ADDR   32'h00000000
`define BYTE_LANE_W      2
`define BYTE_LANE_LAST   2'h3

`endif

// >>> shared/boot_pkg.sv
// Purpose: Types of the reset and boot mode controller.
// Assumes: Used through boot_pkg:: only.
// Notes:   No constants live here; see boot_defines.svh.
package boot_pkg;

    // Boot mode as taken from the straps; the fourth code runs as no boot.
    typedef enum logic [1:0] {
        BOOT_NONE,
        BOOT_HOST,
        BOOT_EXTERNAL_MEMORY_INTERFACE,
        BOOT_RSVD
    } boot_mode_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_CAPTURE,
        ST_HOST_WAIT,
        ST_COPY_REQ,
        ST_COPY_WAIT,
        ST_COPY_DRAIN,
        ST_RUN
    } boot_state_t;

endpackage

// >>> shared/boot_copy_if.sv
// Purpose: Byte-to-word packing channel between sequencer and packer.
// Assumes: One clock; byteValid is a one-cycle strobe.
// Notes:   wordValid pulses once per four accepted bytes.
`timescale 1ns/1ps
interface boot_copy_if;
    logic        byteValid;
    logic [7:0]  byteData;
    logic        bigEndian;
    logic        wordValid;
    logic [31:0] wordData;

    modport src  (output byteValid, byteData, bigEndian,
                  input  wordValid, wordData);
    modport pack (input  byteValid, byteData, bigEndian,
                  output wordValid, wordData);
endinterface

// >>> logic/boot_byte_packer.sv
// Purpose: Packs consecutive ROM bytes into 32-bit instruction words.
// Assumes: Bytes arrive in ascending address order.
// Notes:   Byte order follows the system endian strap.
`timescale 1ns/1ps
`include "boot_defines.svh"
module boot_byte_packer (
    input wire logic clk,
    input wire logic rstn,
    boot_copy_if.pack cp
);

    // ------------------------------------------------------------------
    // Lane placement
    // ------------------------------------------------------------------
    // Little endian puts the first byte low, big endian puts it high.
    function automatic logic [31:0] placeByte(
        input logic [31:0] word,
        input logic [7:0]  data,
        input logic [1:0]  lane,
        input logic        big
    );
        logic [1:0]  pos;
        logic [31:0] res;
        pos = big ? (`BYTE_LANE_LAST - lane) : lane;
        res = word;
        res[pos*8 +: 8] = data;
        return res;
    endfunction

    logic [1:0]  lane_reg;
    logic [31:0] acc_reg;
    logic        wordValid_reg;
    logic [31:0] wordData_reg;
    wire  [31:0] accNext  = placeByte(acc_reg, cp.byteData, lane_reg,
                                      cp.bigEndian);
    wire         laneLast = (lane_reg == `BYTE_LANE_LAST);

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    // Four bytes make one word; the word is handed over on the fourth.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lane_reg      <= '0;
            acc_reg       <= '0;
            wordValid_reg <= 1'b0;
            wordData_reg  <= '0;
        end else begin
            wordValid_reg <= cp.byteValid && laneLast;
            if (cp.byteValid) begin
                lane_reg <= lane_reg + 2'h1;
                acc_reg  <= accNext;
                if (laneLast) begin
                    wordData_reg <= accNext;
                end
            end
        end
    end

    assign cp.wordValid = wordValid_reg;
    assign cp.wordData  = wordData_reg;

endmodule

// >>> logic/reset_boot_mode_controller.sv
// Purpose: Reset hold and boot sequencing of the processor.
// Assumes: 100 MHz clk; rstn synchronous active low; ROM and memory
//          ports share clk.
// Notes:   Straps are synchronised and captured once after release.
//
// Operation
// - While rstn is low everything but the strap synchronisers stays in its reset state.
// - On release the device runs with the captured boot configuration.
// - Host boot keeps the CPU stalled while the rest of the device runs.
// - In host boot that bit releases the stall; CPU starts at zero.
// - The releasing bit set is not raised as a CPU interrupt.
// - The bit releases the stall only when host boot is selected.
// - CPU must clear the bit; until then no further interrupts arrive.
// - During host boot the host may write and read all memory.
// - External boot copies 1 KB from chip select one to zero.
// - Consecutive ROM bytes are packed into 32-bit words.
// - The copy runs as one single-frame block transfer.
// - When the copy completes the stall is released; CPU starts at zero.
// - No boot runs from address zero at once with no stall.
`timescale 1ns/1ps
`include "boot_defines.svh"
module reset_boot_mode_controller (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [1:0]  bootModePin,
    input  wire logic        bigEndianPin,
    input  wire logic        hostIntSet,
    input  wire logic        cpuIntClear,
    input  wire logic        romAck,
    input  wire logic [7:0]  romData,
    output logic             sysRun,
    output logic             cpuStall,
    output logic [31:0]      cpuStartAddr,
    output logic             hostMemEnable,
    output logic             hostIntBit,
    output logic             cpuIntPulse,
    output logic             dmaFrameActive,
    output logic             romDefaultTiming,
    output logic             romReq,
    output logic [31:0]      romAddr,
    output logic             memWr,
    output logic [31:0]      memWrAddr,
    output logic [31:0]      memWrData
);

    // ------------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------------
    // Straps come from pins; no reset so they are settled at release.
    logic [1:0] modeMeta_reg;
    logic [1:0] modeSync_reg;
    logic       endMeta_reg;
    logic       endSync_reg;

    always_ff @(posedge clk) begin
        modeMeta_reg <= bootModePin;
        modeSync_reg <= modeMeta_reg;
        endMeta_reg  <= bigEndianPin;
        endSync_reg  <= endMeta_reg;
    end

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    boot_pkg::boot_state_t state_reg;
    boot_pkg::boot_state_t state_next;
    boot_pkg::boot_mode_t  bootMode_reg;
    logic                  bigEnd_reg;
    logic [10:0]           byteCnt_reg;
    logic [10:0]           wordAddr_reg;
    logic                  sysRun_reg;
    logic                  cpuStall_reg;
    logic                  hostMem_reg;
    logic                  hostIntBit_reg;
    logic                  cpuInt_reg;
    logic                  romReq_reg;
    logic                  memWr_reg;
    logic [31:0]           memWrData_reg;
    logic                  dmaFrame_reg;

    boot_copy_if cpIf ();

    boot_byte_packer packer (
        .clk  (clk),
        .rstn (rstn),
        .cp   (cpIf)
    );

    // ------------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------------
    // The reserved strap code is run as no boot rather than hanging.
    wire boot_pkg::boot_mode_t modeSync = boot_pkg::boot_mode_t'(modeSync_reg);
    wire inHost   = (state_reg == boot_pkg::ST_HOST_WAIT);
    wire inCopy   = (state_reg == boot_pkg::ST_COPY_REQ)
                 || (state_reg == boot_pkg::ST_COPY_WAIT)
                 || (state_reg == boot_pkg::ST_COPY_DRAIN);
    wire byteTake = (state_reg == boot_pkg::ST_COPY_WAIT) && romAck;
    wire lastByte = (byteCnt_reg == `BOOT_LAST_BYTE);
    wire intTake  = hostIntSet && !hostIntBit_reg;
    wire copyDone = (state_reg == boot_pkg::ST_COPY_DRAIN) && memWr_reg;

    assign cpIf.byteValid = byteTake;
    assign cpIf.byteData  = romData;
    assign cpIf.bigEndian = bigEnd_reg;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // One block of fixed size is read byte by byte, one request in flight.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            boot_pkg::ST_CAPTURE: begin
                if (modeSync == boot_pkg::BOOT_HOST) begin
                    state_next = boot_pkg::ST_HOST_WAIT;
                end else if (modeSync == boot_pkg::BOOT_EXTERNAL_MEMORY_INTERFACE) begin
                    state_next = boot_pkg::ST_COPY_REQ;
                end else begin
                    state_next = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_HOST_WAIT: begin
                if (hostIntSet && bootMode_reg == boot_pkg::BOOT_HOST) begin
                    state_next = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_COPY_REQ: begin
                state_next = boot_pkg::ST_COPY_WAIT;
            end
            boot_pkg::ST_COPY_WAIT: begin
                if (romAck) begin
                    state_next = lastByte ? boot_pkg::ST_COPY_DRAIN
                                          : boot_pkg::ST_COPY_REQ;
                end
            end
            boot_pkg::ST_COPY_DRAIN: begin
                if (memWr_reg) begin
                    state_next = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_RUN: begin
                state_next = boot_pkg::ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer and strap capture
    // ------------------------------------------------------------------
    // Mode is sampled only in the capture cycle so a strap glitch later
    // cannot redirect a boot that is under way.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg    <= boot_pkg::ST_CAPTURE;
            bootMode_reg <= boot_pkg::BOOT_NONE;
            bigEnd_reg   <= 1'b0;
            sysRun_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            sysRun_reg <= 1'b1;
            if (state_reg == boot_pkg::ST_CAPTURE) begin
                bootMode_reg <= modeSync;
                bigEnd_reg   <= endSync_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // CPU stall and host access
    // ------------------------------------------------------------------
    // Stall is held through capture; only no boot drops it at once.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpuStall_reg <= 1'b1;
            hostMem_reg  <= 1'b0;
        end else begin
            cpuStall_reg <= (state_next != boot_pkg::ST_RUN);
            if (state_next == boot_pkg::ST_HOST_WAIT) begin
                hostMem_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Host-to-CPU interrupt bit
    // ------------------------------------------------------------------
    // A set in the clearing cycle wins, so no host event is lost. A set
    // while the bit is still high is not accepted and gives no pulse.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hostIntBit_reg <= 1'b0;
            cpuInt_reg     <= 1'b0;
        end else begin
            hostIntBit_reg <= hostIntSet || (hostIntBit_reg && !cpuIntClear);
            cpuInt_reg     <= intTake
                           && (state_reg == boot_pkg::ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Boot copy engine
    // ------------------------------------------------------------------
    // Destination words follow the packer, so writes trail the reads.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            byteCnt_reg   <= '0;
            wordAddr_reg  <= '0;
            romReq_reg    <= 1'b0;
            memWr_reg     <= 1'b0;
            memWrData_reg <= '0;
            dmaFrame_reg  <= 1'b0;
        end else begin
            romReq_reg <= (state_next == boot_pkg::ST_COPY_REQ);
            // The frame covers the whole copy, drain included.
            dmaFrame_reg <= (state_next == boot_pkg::ST_COPY_REQ)
                         || (state_next == boot_pkg::ST_COPY_WAIT)
                         || (state_next == boot_pkg::ST_COPY_DRAIN);
            memWr_reg  <= cpIf.wordValid;
            if (byteTake) begin
                byteCnt_reg <= byteCnt_reg + 11'h1;
            end
            if (cpIf.wordValid) begin
                memWrData_reg <= cpIf.wordData;
            end
            if (memWr_reg) begin
                wordAddr_reg <= wordAddr_reg + 11'h4;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Start address is a constant; it is still a register bit image.
    assign sysRun           = sysRun_reg;
    assign cpuStall         = cpuStall_reg;
    assign cpuStartAddr     = `CPU_START_ADDR;
    assign hostMemEnable    = hostMem_reg;
    assign hostIntBit       = hostIntBit_reg;
    assign cpuIntPulse      = cpuInt_reg;
    assign dmaFrameActive   = dmaFrame_reg;
    assign romDefaultTiming = romReq_reg;
    assign romReq           = romReq_reg;
    assign romAddr          = `BOOT_SRC_BASE + {21'h0, byteCnt_reg};
    assign memWr            = memWr_reg;
    assign memWrAddr        = `BOOT_DEST_BASE + {21'h0, wordAddr_reg};
    assign memWrData        = memWrData_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    stall_in_reset_a: assert property (
        disable iff (1'b0) !rstn |=> cpuStall_reg && !sysRun_reg
    ) else $error("device not held in reset");

    run_after_release_a: assert property (
        $rose(rstn) |=> sysRun_reg ##1 (state_reg != boot_pkg::ST_CAPTURE)
    ) else $error("device did not start after release");

    host_stall_hold_a: assert property (
        inHost |-> cpuStall_reg && sysRun_reg && hostMem_reg
    ) else $error("host boot lost its stall");

    host_release_a: assert property (
        inHost && hostIntSet |=> !cpuStall_reg
                               && state_reg == boot_pkg::ST_RUN
    ) else $error("host bit did not release stall");

    no_latch_release_a: assert property (
        inHost && hostIntSet |=> !cpuInt_reg ##1 !cpuInt_reg
    ) else $error("releasing set raised an interrupt");

    other_mode_hold_a: assert property (
        inCopy && hostIntSet && !copyDone |=> cpuStall_reg
    ) else $error("host bit released stall outside host boot");

    int_blocked_a: assert property (
        hostIntBit_reg && !cpuIntClear |=> hostIntBit_reg && !cpuInt_reg
    ) else $error("interrupt accepted while bit high");

    copy_stalled_a: assert property (
        memWr_reg |-> cpuStall_reg && memWrAddr < 32'h00000400
    ) else $error("boot write outside stall or block");

    copy_done_a: assert property (
        copyDone |-> memWrAddr == 32'h000003FC ##1 !cpuStall_reg
    ) else $error("copy end did not release stall");

    noboot_run_a: assert property (
        state_reg == boot_pkg::ST_CAPTURE && modeSync != boot_pkg::BOOT_HOST
        && modeSync != boot_pkg::BOOT_EXTERNAL_MEMORY_INTERFACE |=> !cpuStall_reg
    ) else $error("no boot still stalled");

    mode_stable_a: assert property (
        state_reg != boot_pkg::ST_CAPTURE |=> $stable(bootMode_reg)
    ) else $error("boot mode changed during boot");

    host_boot_c: cover property (inHost ##[1:20] !cpuStall_reg);
    copy_boot_c: cover property (copyDone ##1 !cpuStall_reg);
    cpu_int_c:   cover property (cpuInt_reg);

endmodule

// >>> sim/boot_rom_model.sv
// Purpose: Behavioural boot ROM on chip select one, answering byte reads.
// Assumes: One request outstanding; answer after a chosen number of idle cycles.
// Notes:   Between answers the data lines toggle so a stale byte never matches.
`timescale 1ns/1ps
module boot_rom_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        romReq,
    input  wire logic [31:0] romAddr,
    input  wire logic [3:0]  latency,
    output logic             romAck,
    output logic [7:0]       romData
);
    logic [31:0] addrReg;
    logic [3:0]  waitReg;
    logic        busyReg;

    // ----------------------------------------------------------------------
    // Image contents
    // ----------------------------------------------------------------------
    // The image is stored in system byte order; lane choice is the packer's job.
    function automatic logic [7:0] imageByte(input logic [31:0] a);
        return a[7:0] ^ {4'h0, a[9:8], 2'h0} ^ 8'hA5;
    endfunction

    // ----------------------------------------------------------------------
    // Read responder
    // ----------------------------------------------------------------------
    // A slow answer tests that the copy waits for every byte, however late.
    always @(posedge clk) begin
        romAck  <= 1'h0;
        romData <= ~romData;
        if (!rstn) begin
            busyReg <= 1'h0;
            romData <= 8'h00;
        end else if (busyReg) begin
            if (waitReg == 4'h0) begin
                romAck  <= 1'h1;
                romData <= imageByte(addrReg);
                busyReg <= 1'h0;
            end else begin
                waitReg <= waitReg - 4'h1;
            end
        end else if (romReq) begin
            busyReg <= 1'h1;
            addrReg <= romAddr;
            waitReg <= latency;
        end
    end
endmodule

// >>> sim/tb_reset_boot_mode_controller.sv
// Purpose: Self-checking bench of the reset and boot mode controller.
// Assumes: Inputs change 1 ns after the rising edge; outputs read then.
// Notes:   The ROM model answers byte reads; the bench plays host and CPU.
`timescale 1ns/1ps
`include "boot_defines.svh"
module tb_reset_boot_mode_controller;
    logic clk, rstn, bigEndianPin, hostIntSet, cpuIntClear, romAck;
    logic [1:0] bootModePin;
    logic [7:0] romData;
    logic [3:0] latency;
    logic sysRun, cpuStall, hostMemEnable, hostIntBit, cpuIntPulse;
    logic dmaFrameActive, romDefaultTiming, romReq, memWr;
    logic [31:0] cpuStartAddr, romAddr, memWrAddr, memWrData;
    int errors, comparisons, cycles;

    reset_boot_mode_controller i_dut (.clk(clk), .rstn(rstn), .bootModePin(bootModePin),
        .bigEndianPin(bigEndianPin), .hostIntSet(hostIntSet), .cpuIntClear(cpuIntClear),
        .romAck(romAck), .romData(romData), .sysRun(sysRun), .cpuStall(cpuStall),
        .cpuStartAddr(cpuStartAddr), .hostMemEnable(hostMemEnable), .hostIntBit(hostIntBit),
        .cpuIntPulse(cpuIntPulse), .dmaFrameActive(dmaFrameActive),
        .romDefaultTiming(romDefaultTiming), .romReq(romReq), .romAddr(romAddr),
        .memWr(memWr), .memWrAddr(memWrAddr), .memWrData(memWrData));

    boot_rom_model i_rom (.clk(clk), .rstn(rstn), .romReq(romReq), .romAddr(romAddr),
        .latency(latency), .romAck(romAck), .romData(romData));

    // ----------------------------------------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------------------------------------
    // The clock runs at 100 MHz.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Two copies at up to three idle cycles a byte stay well below this ceiling.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            $display("Error at %0t: run did not finish in time", $time);
            test_done();
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The bench keeps its own copy of the ROM image formula.
    function automatic logic [7:0] expByte(input logic [31:0] a);
        return a[7:0] ^ {4'h0, a[9:8], 2'h0} ^ 8'hA5;
    endfunction

    // Resets for eight cycles with the given straps, then releases.
    task automatic doReset(input logic [1:0] mode, input logic big);
        rstn = 1'h0;
        bootModePin = mode;
        bigEndianPin = big;
        repeat (8) tick();
        chkBit(sysRun, 1'h0, "sysRun in reset");
        chkBit(cpuStall, 1'h1, "cpuStall in reset");
        chkBit(romReq, 1'h0, "romReq in reset");
        chkWord(romAddr, `BOOT_SRC_BASE, "romAddr in reset");
        rstn = 1'h1;
        tick();
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'h1;
        tick();
        sig = 1'h0;
    endtask

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    // No boot: runs at once; the interrupt bit then acts as a plain interrupt.
    task automatic testNoBoot(input logic [1:0] mode);
        doReset(mode, 1'h0);
        chkBit(cpuStall, 1'h0, "no boot stall");
        chkBit(sysRun, 1'h1, "no boot run");
        chkWord(cpuStartAddr, `CPU_START_ADDR, "no boot start");
        repeat (3) tick();
        chkBit(hostMemEnable, 1'h0, "no boot host memory");
        pulse(hostIntSet);
        chkBit(cpuIntPulse, 1'h1, "first interrupt");
        chkBit(cpuStall, 1'h0, "stall after set");
        tick();
        pulse(hostIntSet);
        chkBit(cpuIntPulse, 1'h0, "set while pending");
        pulse(cpuIntClear);
        chkBit(hostIntBit, 1'h0, "bit cleared");
        pulse(hostIntSet);
        chkBit(cpuIntPulse, 1'h1, "interrupt after clear");
        chkBit(romReq, 1'h0, "no copy in no boot");
        $display("Test no boot mode %0d done", mode);
    endtask

    // Host boot: stall holds despite strap changes until the host sets the bit.
    task automatic testHost();
        logic sawReq;
        sawReq = 1'h0;
        doReset(`BOOT_MODE_HOST, 1'h0);
        bootModePin = `BOOT_MODE_EXTERNAL_MEMORY_INTERFACE;
        repeat (20) begin
            tick();
            sawReq = sawReq | romReq;
        end
        chkBit(cpuStall, 1'h1, "host wait stall");
        chkBit(sysRun, 1'h1, "host wait device runs");
        chkBit(hostMemEnable, 1'h1, "host memory access");
        chkBit(sawReq, 1'h0, "strap change ignored");
        pulse(hostIntSet);
        chkBit(cpuStall, 1'h0, "stall released");
        chkBit(hostIntBit, 1'h1, "bit set");
        chkBit(cpuIntPulse, 1'h0, "release not delivered");
        chkWord(cpuStartAddr, `CPU_START_ADDR, "host start");
        tick();
        chkBit(cpuIntPulse, 1'h0, "release not delivered later");
        pulse(cpuIntClear);
        chkBit(hostIntBit, 1'h0, "bit cleared after boot");
        $display("Test host boot done");
    endtask

    // Copy boot: 1024 bytes packed to 256 words at 0, a set mid copy raises the bit but neither interrupts nor releases the stall.
    task automatic testCopy(input logic big, input logic [3:0] lat);
        int reqN, wordN, n;
        logic sawPulse;
        logic [31:0] b, expW;
        reqN = 0;
        wordN = 0;
        sawPulse = 1'h0;
        latency = lat;
        doReset(`BOOT_MODE_EXTERNAL_MEMORY_INTERFACE, big);
        for (n = 0; n < 20000 && wordN < 256; n++) begin
            sawPulse = sawPulse | cpuIntPulse;
            if (romReq === 1'h1) begin
                chkWord(romAddr, `BOOT_SRC_BASE + reqN, "rom address");
                chkBit(romDefaultTiming, 1'h1, "default timing");
                reqN++;
            end
            if (memWr === 1'h1) begin
                b = `BOOT_SRC_BASE + 4 * wordN;
                expW = big ? {expByte(b), expByte(b + 1), expByte(b + 2), expByte(b + 3)}
                           : {expByte(b + 3), expByte(b + 2), expByte(b + 1), expByte(b)};
                chkWord(memWrAddr, `BOOT_DEST_BASE + 4 * wordN, "word address");
                chkWord(memWrData, expW, "packed word");
                chkBit(cpuStall, 1'h1, "stall during copy");
                chkBit(dmaFrameActive, 1'h1, "frame active");
                wordN++;
            end
            // One host set in mid copy; the raised bit ends it after one cycle.
            hostIntSet = (wordN == 100 && reqN == 401 && hostIntBit === 1'h0) ? 1'h1 : 1'h0;
            tick();
        end
        hostIntSet = 1'h0;
        tick();
        chkWord(wordN, 256, "word count");
        chkWord(reqN, 1024, "read count");
        chkBit(cpuStall, 1'h0, "stall released after copy");
        chkBit(dmaFrameActive, 1'h0, "frame ended");
        chkBit(sawPulse, 1'h0, "set during copy");
        chkBit(hostIntBit, 1'h1, "bit set during copy");
        $display("Test copy boot endian %0d done", big);
    endtask

    // ----------------------------------------------------------------------
    // Closing report
    // ----------------------------------------------------------------------
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        rstn = 1'h0;
        bootModePin = `BOOT_MODE_NONE;
        bigEndianPin = 1'h0;
        hostIntSet = 1'h0;
        cpuIntClear = 1'h0;
        latency = 4'h0;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        testNoBoot(`BOOT_MODE_NONE);
        testNoBoot(2'h3);
        testHost();
        testCopy(1'h0, 4'h0);
        testCopy(1'h1, 4'h3);
        test_done();
    end
endmodule
